// File: hw/mmf_access.sv
`default_nettype none
// ------------------------------------------------------------
// privilege and trap check
// ------------------------------------------------------------
module mmf_access (
    input  wire logic             i_is_feat,
    input  wire mmf_pkg::mmf_pl_t i_level,
    input  wire logic             i_write,
    input  wire logic             i_l2_present,
    input  wire logic             i_gen_trap,
    input  wire logic             i_id_group3_trap_bit,
    input  wire logic             i_primary_group0_trap_bit,
    output mmf_pkg::mmf_res_t     o_res
);
    always_comb begin
        o_res = mmf_pkg::MMF_RES_UNDEF;
        if (!i_write) begin
            case (i_level)
                mmf_pkg::MMF_PL2: begin
                    o_res = mmf_pkg::MMF_RES_OK;
                end
                mmf_pkg::MMF_PL1: begin
                    if (i_gen_trap) begin
                        o_res = mmf_pkg::MMF_RES_UNDEF;
                    end else if (i_l2_present && i_is_feat &&
                                 (i_id_group3_trap_bit || i_primary_group0_trap_bit)) begin
                        o_res = mmf_pkg::MMF_RES_TRAP;
                    end else begin
                        o_res = mmf_pkg::MMF_RES_OK;
                    end
                end
                default: begin
                    o_res = mmf_pkg::MMF_RES_UNDEF;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/mmf_fields.sv
`default_nettype none
// ------------------------------------------------------------
// constant feature words
// ------------------------------------------------------------
module mmf_fields #(
    parameter logic [3:0] P_INNER_SHR = mmf_pkg::SHR_IGNORED,
    parameter logic [3:0] P_OUTER_SHR = mmf_pkg::SHR_IGNORED,
    parameter logic [3:0] P_TCM       = mmf_pkg::TCM_NONE,
    parameter logic [3:0] P_WFI       = mmf_pkg::WFI_STALL
) (
    output logic [31:0] o_feat0,
    output logic [31:0] o_feat2,
    output logic        o_codes_ok
);
    function automatic logic shr_ok(input logic [3:0] c);
        shr_ok = (c == mmf_pkg::SHR_NONCACHE) || (c == mmf_pkg::SHR_COHERENT) ||
                 (c == mmf_pkg::SHR_IGNORED);
    endfunction

    // reserved codes forced to a legal default
    logic [3:0] inner_c;
    logic [3:0] outer_c;
    logic [3:0] tcm_c;
    logic [3:0] wfi_c;
    assign inner_c = shr_ok(P_INNER_SHR) ? P_INNER_SHR : mmf_pkg::SHR_IGNORED;
    assign outer_c = shr_ok(P_OUTER_SHR) ? P_OUTER_SHR : mmf_pkg::SHR_IGNORED;
    assign tcm_c = (P_TCM == mmf_pkg::TCM_IMPDEF) ? mmf_pkg::TCM_IMPDEF
                                                  : mmf_pkg::TCM_NONE;
    assign wfi_c = (P_WFI == mmf_pkg::WFI_STALL) ? mmf_pkg::WFI_STALL
                                                 : mmf_pkg::WFI_NONE;

    // share levels fixed at two so the inner field is meaningful
    assign o_feat0 = {inner_c,
                      mmf_pkg::FAST_CONTEXT_SWITCH_FIELD_NONE,
                      mmf_pkg::AUX_CTRL_FAULT,
                      tcm_c,
                      mmf_pkg::SHARE_TWO,
                      outer_c,
                      mmf_pkg::PMS_BASE_LIMIT,
                      mmf_pkg::VMS_NONE};
    // split tlb field zero since unified tlb field is zero
    assign o_feat2 = {mmf_pkg::HAF_NONE,
                      wfi_c,
                      mmf_pkg::BARR_ALL,
                      mmf_pkg::UTLB_NONE,
                      mmf_pkg::STLB_ZERO,
                      mmf_pkg::RANGE_NONE,
                      mmf_pkg::FETCH_NONE,
                      mmf_pkg::FETCH_NONE};
    assign o_codes_ok = shr_ok(o_feat0[31:28]) && shr_ok(o_feat0[11:8]);
endmodule
`default_nettype wire

// File: hw/mmf_pkg.sv
`default_nettype none
package mmf_pkg;
    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    localparam logic [3:0] COPROC_SYS      = 4'hf;
    localparam logic [2:0] OPC1_ID         = 3'h0;
    localparam logic [3:0] CRN_ID          = 4'h0;
    localparam logic [3:0] CRM_FEAT        = 4'h1;
    localparam logic [2:0] OPC2_MMF0       = 3'h4;
    localparam logic [2:0] OPC2_MMF2       = 3'h6;
    localparam logic [3:0] CRM_AUX         = 4'h0;
    localparam logic [3:0] CRN_AUX_CTRL    = 4'h1;
    localparam logic [3:0] CRN_AUX_FAULT   = 4'h5;
    localparam logic [2:0] OPC2_AUX        = 3'h1;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int F_HI   = 28;
    localparam int F_6    = 24;
    localparam int F_5    = 20;
    localparam int F_4    = 16;
    localparam int F_3    = 12;
    localparam int F_2    = 8;
    localparam int F_1    = 4;
    localparam int F_0    = 0;
    // ------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------
    localparam logic [3:0] SHR_NONCACHE    = 4'h0;
    localparam logic [3:0] SHR_COHERENT    = 4'h1;
    localparam logic [3:0] SHR_IGNORED     = 4'hf;
    localparam logic [3:0] FAST_CONTEXT_SWITCH_FIELD_NONE       = 4'h0;
    localparam logic [3:0] AUX_CTRL_FAULT  = 4'h2;
    localparam logic [3:0] TCM_NONE        = 4'h0;
    localparam logic [3:0] TCM_IMPDEF      = 4'h1;
    localparam logic [3:0] SHARE_TWO       = 4'h1;
    localparam logic [3:0] PMS_BASE_LIMIT  = 4'h4;
    localparam logic [3:0] VMS_NONE        = 4'h0;
    localparam logic [3:0] HAF_NONE        = 4'h0;
    localparam logic [3:0] WFI_NONE        = 4'h0;
    localparam logic [3:0] WFI_STALL       = 4'h1;
    localparam logic [3:0] BARR_ALL        = 4'h2;
    localparam logic [3:0] UTLB_NONE       = 4'h0;
    localparam logic [3:0] STLB_ZERO       = 4'h0;
    localparam logic [3:0] RANGE_NONE      = 4'h0;
    localparam logic [3:0] FETCH_NONE      = 4'h0;
    localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
    // ------------------------------------------------------------
    // privilege and result
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MMF_PL0, MMF_PL1, MMF_PL2, MMF_PL_RSV} mmf_pl_t;
    typedef enum logic [1:0] {MMF_RES_OK, MMF_RES_UNDEF, MMF_RES_TRAP, MMF_RES_NONE} mmf_res_t;
endpackage
`default_nettype wire

// File: hw/mmf_regs.sv
`default_nettype none
// How it works
// - first feature word is 32 read-only bits in eight 4-bit fields
// - innermost share field reads 0000, 0001 or 1111 only
// - innermost field meaningful only with share level field 0001
// - fast context switch field reads 0000
// - auxiliary register field reads 0010
// - access to an unimplemented auxiliary register is undefined
// - tightly coupled memory field reads 0000 or 0001
// - share level field reads 0001, two levels
// - outermost share field reads 0000, 0001 or 1111 only
// - protected memory field reads 0100
// - virtual memory field reads 0000
// - first word decoded at opc1 0, opc2 4, crn 0, coproc f, crm 1
// - no access unprivileged; read-only at levels 1 and 2
// - level 1 reads trap to level 2 with id group 3 trap set
// - level 1 reads trap to level 2 with group 0 trap set
// - hardware access flag field reads 0000
// - wait-for-interrupt stall field reads 0000 or 0001
// - barrier field reads 0010
// - unified tlb field reads 0000
// - split tlb field implementation defined only when unified nonzero
// - range maintenance field reads 0000
// - background fetch field reads 0000
// - foreground fetch field reads 0000
module mmf_regs #(
    parameter logic [3:0] P_INNER_SHR = mmf_pkg::SHR_IGNORED,
    parameter logic [3:0] P_OUTER_SHR = mmf_pkg::SHR_IGNORED,
    parameter logic [3:0] P_TCM       = mmf_pkg::TCM_NONE,
    parameter logic [3:0] P_WFI       = mmf_pkg::WFI_STALL
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    input  wire logic             i_req,
    input  wire logic             i_write,
    input  wire logic [3:0]       i_coproc,
    input  wire logic [2:0]       i_opc1,
    input  wire logic [3:0]       i_crn,
    input  wire logic [3:0]       i_crm,
    input  wire logic [2:0]       i_opc2,
    input  wire mmf_pkg::mmf_pl_t i_level,
    input  wire logic             i_l2_present,
    input  wire logic             i_general_exception_trap_flag,
    input  wire logic             i_id_group3_trap_bit,
    input  wire logic             i_primary_group0_trap_bit,
    output logic                  o_done,
    output logic [31:0]           o_rdata,
    output logic                  o_undef,
    output logic                  o_trap_l2
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_sys_id(input logic [3:0] cp, input logic [2:0] o1,
                                       input logic [3:0] n, input logic [3:0] m);
        is_sys_id = (cp == mmf_pkg::COPROC_SYS) && (o1 == mmf_pkg::OPC1_ID) &&
                    (n == mmf_pkg::CRN_ID) && (m == mmf_pkg::CRM_FEAT);
    endfunction

    logic        hit0;
    logic        hit2;
    logic        aux_hit;
    logic        is_feat;
    logic [31:0] feat0;
    logic [31:0] feat2;
    logic        codes_ok;
    mmf_pkg::mmf_res_t res;

    assign hit0 = is_sys_id(i_coproc, i_opc1, i_crn, i_crm) &&
                  (i_opc2 == mmf_pkg::OPC2_MMF0);
    assign hit2 = is_sys_id(i_coproc, i_opc1, i_crn, i_crm) &&
                  (i_opc2 == mmf_pkg::OPC2_MMF2);
    // aux control and aux fault status are implemented, so they decode as known
    assign aux_hit = (i_coproc == mmf_pkg::COPROC_SYS) && (i_opc1 == mmf_pkg::OPC1_ID) &&
                     (i_crm == mmf_pkg::CRM_AUX) && (i_opc2 <= mmf_pkg::OPC2_AUX) &&
                     ((i_crn == mmf_pkg::CRN_AUX_CTRL) || (i_crn == mmf_pkg::CRN_AUX_FAULT));
    assign is_feat = hit0 || hit2;

    // ------------------------------------------------------------
    // feature words and access check
    // ------------------------------------------------------------
    mmf_fields #(
        .P_INNER_SHR (P_INNER_SHR),
        .P_OUTER_SHR (P_OUTER_SHR),
        .P_TCM       (P_TCM),
        .P_WFI       (P_WFI)
    ) u_fields (
        .o_feat0    (feat0),
        .o_feat2    (feat2),
        .o_codes_ok (codes_ok)
    );

    mmf_access u_access (
        .i_is_feat                 (is_feat),
        .i_level                   (i_level),
        .i_write                   (i_write),
        .i_l2_present              (i_l2_present),
        .i_gen_trap                (i_general_exception_trap_flag),
        .i_id_group3_trap_bit      (i_id_group3_trap_bit),
        .i_primary_group0_trap_bit (i_primary_group0_trap_bit),
        .o_res                     (res)
    );

    // ------------------------------------------------------------
    // answer registers
    // ------------------------------------------------------------
    logic        done_reg;
    logic        done_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        undef_reg;
    logic        undef_next;
    logic        trap_reg;
    logic        trap_next;

    always_comb begin
        done_next  = i_req;
        rdata_next = mmf_pkg::READ_ZERO;
        undef_next = 1'b0;
        trap_next  = 1'b0;
        if (i_req) begin
            if (is_feat) begin
                case (res)
                    mmf_pkg::MMF_RES_OK: begin
                        rdata_next = hit0 ? feat0 : feat2;
                    end
                    mmf_pkg::MMF_RES_TRAP: begin
                        trap_next = 1'b1;
                    end
                    default: begin
                        undef_next = 1'b1;
                    end
                endcase
            end else if (!aux_hit) begin
                undef_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            done_reg  <= 1'b0;
            rdata_reg <= mmf_pkg::READ_ZERO;
            undef_reg <= 1'b0;
            trap_reg  <= 1'b0;
        end else begin
            done_reg  <= done_next;
            rdata_reg <= rdata_next;
            undef_reg <= undef_next;
            trap_reg  <= trap_next;
        end
    end

    assign o_done    = done_reg;
    assign o_rdata   = rdata_reg;
    assign o_undef   = undef_reg;
    assign o_trap_l2 = trap_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    feat0_value_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && hit0 && res == mmf_pkg::MMF_RES_OK) |=>
        (o_rdata[27:20] == {mmf_pkg::FAST_CONTEXT_SWITCH_FIELD_NONE, mmf_pkg::AUX_CTRL_FAULT} &&
         o_rdata[15:12] == mmf_pkg::SHARE_TWO &&
         o_rdata[7:0] == {mmf_pkg::PMS_BASE_LIMIT, mmf_pkg::VMS_NONE}))
        else $error("first feature word low fields wrong");
    feat2_value_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && hit2 && res == mmf_pkg::MMF_RES_OK) |=>
        (o_rdata[31:28] == 4'h0 && o_rdata[23:0] == 24'h200000))
        else $error("second feature word fields wrong");
    share_codes_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        codes_ok && feat0[15:12] == 4'h1)
        else $error("share field reserved code");
    unpriv_deny_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && is_feat && i_level == mmf_pkg::MMF_PL0) |=> (o_undef && !o_trap_l2))
        else $error("unprivileged read not refused");
    trap_route_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && is_feat && !i_write && i_level == mmf_pkg::MMF_PL1 && i_l2_present &&
         !i_general_exception_trap_flag && (i_id_group3_trap_bit || i_primary_group0_trap_bit))
        |=> (o_trap_l2 && o_rdata == 32'h0000_0000))
        else $error("level 1 read not trapped");
    pl2_read_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && is_feat && !i_write && i_level == mmf_pkg::MMF_PL2) |=> !o_trap_l2 && !o_undef)
        else $error("level 2 read refused");
    write_deny_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && is_feat && i_write) |=> o_undef)
        else $error("write to read-only word accepted");
    aux_undef_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (i_req && !is_feat && !aux_hit) |=> o_undef)
        else $error("unknown register not undefined");
    done_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
        i_req |=> o_done ##0 $stable(feat0) ##0 $stable(feat2))
        else $error("answer missing or words changed");
endmodule
`default_nettype wire

// File: sim/test_mmf_regs.sv
`default_nettype none
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_mmf_regs;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [3:0]  CP = mmf_pkg::COPROC_SYS;
    localparam logic [31:0] EXP0 = {mmf_pkg::SHR_IGNORED, mmf_pkg::FAST_CONTEXT_SWITCH_FIELD_NONE,
        mmf_pkg::AUX_CTRL_FAULT, mmf_pkg::TCM_NONE, mmf_pkg::SHARE_TWO,
        mmf_pkg::SHR_IGNORED, mmf_pkg::PMS_BASE_LIMIT, mmf_pkg::VMS_NONE};
    localparam logic [31:0] EXP2 = 32'h0120_0000;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              req = 1'b0;
    logic              wr = 1'b0;
    logic [3:0]        coproc = 4'h0;
    logic [2:0]        opc1 = 3'h0;
    logic [3:0]        crn = 4'h0;
    logic [3:0]        crm = 4'h0;
    logic [2:0]        opc2 = 3'h0;
    mmf_pkg::mmf_pl_t  level = mmf_pkg::MMF_PL1;
    logic              l2 = 1'b0;
    logic              gen = 1'b0;
    logic              t3 = 1'b0;
    logic              t0 = 1'b0;
    logic              done;
    logic [31:0]       rdata;
    logic              undef;
    logic              trap;
    logic [31:0]       rd_q;
    int                mismatches = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    mmf_regs mmf_regs_i (
        .i_core_clk                    (clk),
        .i_srst                        (srst),
        .i_req                         (req),
        .i_write                       (wr),
        .i_coproc                      (coproc),
        .i_opc1                        (opc1),
        .i_crn                         (crn),
        .i_crm                         (crm),
        .i_opc2                        (opc2),
        .i_level                       (level),
        .i_l2_present                  (l2),
        .i_general_exception_trap_flag (gen),
        .i_id_group3_trap_bit          (t3),
        .i_primary_group0_trap_bit     (t0),
        .o_done                        (done),
        .o_rdata                       (rdata),
        .o_undef                       (undef),
        .o_trap_l2                     (trap)
    );
    // ------------------------------------------------------------
    // clock and timeout
    // ------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            mismatches++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic access(input logic w, input logic [3:0] n, input logic [3:0] m,
                          input logic [2:0] o2, input mmf_pkg::mmf_pl_t lv,
                          input logic [31:0] er, input logic eu, input logic et);
        @(posedge clk) #1;
        {req, wr, coproc, opc1, crn, crm, opc2} = {1'b1, w, CP, 3'h0, n, m, o2};
        level = lv;
        @(posedge clk) #1;
        req = 1'b0;
        rd_q = rdata;
        `CHECK(done, 1'b1)
        `CHECK(rdata, er)
        `CHECK(undef, eu)
        `CHECK(trap, et)
        @(posedge clk) #1;
        `CHECK({done, undef, trap}, 3'h0)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_feat0();
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, EXP0, 1'b0, 1'b0);
        `CHECK(rd_q[31:28], 4'hf)
        `CHECK(rd_q[15:12], 4'h1)
        `CHECK(rd_q[27:24], 4'h0)
        `CHECK(rd_q[23:20], 4'h2)
        `CHECK(rd_q[19:16], 4'h0)
        `CHECK(rd_q[15:12], 4'h1)
        `CHECK(rd_q[11:8], 4'hf)
        `CHECK(rd_q[7:4], 4'h4)
        `CHECK(rd_q[3:0], 4'h0)
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL2, EXP0, 1'b0, 1'b0);
    endtask
    task automatic t_feat2();
        access(1'b0, 4'h0, 4'h1, 3'h6, mmf_pkg::MMF_PL1, EXP2, 1'b0, 1'b0);
        `CHECK(rd_q[31:28], 4'h0)
        `CHECK(rd_q[27:24], 4'h1)
        `CHECK(rd_q[23:20], 4'h2)
        `CHECK(rd_q[19:16], 4'h0)
        `CHECK(rd_q[15:12], 4'h0)
        `CHECK(rd_q[11:8], 4'h0)
        `CHECK(rd_q[7:4], 4'h0)
        `CHECK(rd_q[3:0], 4'h0)
    endtask
    task automatic t_refuse();
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL0, 32'h0, 1'b1, 1'b0);
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL_RSV, 32'h0, 1'b1, 1'b0);
        access(1'b1, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, 32'h0, 1'b1, 1'b0);
        access(1'b1, 4'h0, 4'h1, 3'h6, mmf_pkg::MMF_PL2, 32'h0, 1'b1, 1'b0);
        gen = 1'b1;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, 32'h0, 1'b1, 1'b0);
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL2, EXP0, 1'b0, 1'b0);
        gen = 1'b0;
    endtask
    task automatic t_traps();
        {l2, t3, t0} = 3'b110;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, 32'h0, 1'b0, 1'b1);
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL2, EXP0, 1'b0, 1'b0);
        {l2, t3, t0} = 3'b101;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, 32'h0, 1'b0, 1'b1);
        access(1'b0, 4'h0, 4'h1, 3'h6, mmf_pkg::MMF_PL1, 32'h0, 1'b0, 1'b1);
        {l2, t3, t0} = 3'b100;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, EXP0, 1'b0, 1'b0);
        {l2, t3, t0} = 3'b011;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL1, EXP0, 1'b0, 1'b0);
        {l2, t3, t0} = 3'b000;
    endtask
    task automatic t_aux();
        access(1'b0, 4'h1, 4'h0, 3'h0, mmf_pkg::MMF_PL1, 32'h0, 1'b0, 1'b0);
        access(1'b0, 4'h5, 4'h0, 3'h1, mmf_pkg::MMF_PL1, 32'h0, 1'b0, 1'b0);
        access(1'b0, 4'h1, 4'h0, 3'h2, mmf_pkg::MMF_PL1, 32'h0, 1'b1, 1'b0);
        access(1'b0, 4'h0, 4'h1, 3'h7, mmf_pkg::MMF_PL1, 32'h0, 1'b1, 1'b0);
    endtask
    task automatic t_b2b_reset();
        @(posedge clk) #1;
        {req, wr, coproc, opc1, crn, crm, opc2} = {1'b1, 1'b0, CP, 3'h0, 4'h0, 4'h1, 3'h4};
        level = mmf_pkg::MMF_PL1;
        @(posedge clk) #1;
        opc2 = 3'h6;
        `CHECK(rdata, EXP0)
        @(posedge clk) #1;
        srst = 1'b1;
        `CHECK(rdata, EXP2)
        @(posedge clk) #1;
        `CHECK({done, rdata, undef, trap}, 35'h0)
        srst = 1'b0;
        req = 1'b0;
        @(posedge clk) #1;
        access(1'b0, 4'h0, 4'h1, 3'h4, mmf_pkg::MMF_PL2, EXP0, 1'b0, 1'b0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        t_feat0();
        t_feat2();
        t_refuse();
        t_traps();
        t_aux();
        t_b2b_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
